// [logic/ddb_builder.sv]
// Builder of the device-specific diagnostic block, with a Wishbone slave.
// Assumes software fills the fields, then starts a build; bytes leave on a
// valid/ready stream toward the fieldbus engine on the same clock.
//
// Operation
// - Header byte upper two bits are always 00.
// - Header lower six bits hold the block length including the header.
// - Second byte bit 7 selects alarm (0) or status (1) variant.
// - Alarm variant carries a non-reserved alarm type in bits 6:0.
// - Status variant carries a non-reserved status type in bits 6:0.
// - A newer request may replace an older pending one.
// - Third byte holds the slot number, 0 for the whole device.
// - Alarm variant fourth byte upper five bits hold a unique sequence.
// - Fourth byte bit 2 requests acknowledge; master acknowledges by a write.
// - Alarm variant fourth byte bits 1:0 hold the alarm specifier.
// - Status variant fourth byte keeps 7:2 zero, bits 1:0 specifier.
// - Per-module status packs two bits per slot from the fifth byte.
// - Pairs of slots that do not exist are sent as zero.
// - Pair codes: valid, error, wrong module, no module.
// - Other types send module-defined bytes after the specifier byte.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ddb_builder #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Diagnostic byte stream.
  output logic             diag_valid,
  output logic [7:0]       diag_data,
  output logic             diag_last,
  input  wire logic        diag_ready,
  // Status.
  output logic             diag_busy,
  output logic             ack_wait
);
  import ddb_pkg::*;

  typedef enum logic {DDB_IDLE, DDB_EMIT} ddb_state_e;

  typedef struct packed {
    ddb_state_e  fsm;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  head;
    logic [7:0]  slot;
    logic [2:0]  spec;
    logic [7:0]  nslot;
    logic [5:0]  extlen;
    logic        pend;
    logic        err;
    logic        repl;
    logic        ackw;
    logic [4:0]  seq;
    logic [7:0]  s_head;
    logic [7:0]  s_slot;
    logic [2:0]  s_spec;
    logic [4:0]  s_seq;
    logic [7:0]  s_nslot;
    logic [5:0]  s_len;
    logic [5:0]  idx;
    logic        o_valid;
    logic [7:0]  o_data;
    logic        o_last;
  } ddb_state_s;

  ddb_state_s  st;
  ddb_state_s  next_st;

  logic [7:0]  data_mem [DDB_DATA_BYTES];
  logic        access;
  logic        wr_ev;
  logic        mem_hit;
  logic [5:0]  mem_widx;
  logic [5:0]  mem_ridx;
  logic [7:0]  mem_byte;
  logic        f_in_valid;
  logic        f_in_ready;
  logic [8:0]  f_in_data;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [8:0]  f_out_data;
  logic [7:0]  cur_byte;
  logic        start_req;

  // Alarm and status type codes that may be sent.
  function automatic logic code_ok(input logic [7:0] head,
                                   input logic [2:0] spec);
    logic [6:0] t;
    logic       vend;
    t    = head[6:0];
    vend = (t >= DDB_VEND_FIRST) && (t <= DDB_VEND_LAST);
    if (head[DDB_HEAD_VAR] == DDB_VAR_ALARM) begin
      code_ok = vend || ((t >= DDB_AT_FIRST) && (t <= DDB_AT_LAST));
    end else begin
      code_ok = (vend || (t == DDB_ST_MSG) || (t == DDB_ST_MODULE)) &&
                (spec[1:0] != DDB_SSPEC_RSVD);
    end
  endfunction

  // Length of a block, header byte included.
  function automatic logic [5:0] block_len(input logic [7:0] head,
                                           input logic [7:0] nslot,
                                           input logic [5:0] extlen);
    logic [7:0] n;
    logic [7:0] ext;
    n   = (nslot > DDB_MAX_SLOTS) ? DDB_MAX_SLOTS : nslot;
    ext = {2'h0, extlen};
    if (ext > 8'(DDB_DATA_BYTES)) begin
      ext = 8'(DDB_DATA_BYTES);
    end
    if (head == {DDB_VAR_STATUS, DDB_ST_MODULE}) begin
      block_len = 6'(8'(DDB_HDR_BYTES) + ((n + 8'h03) >> 2));
    end else begin
      block_len = 6'(8'(DDB_HDR_BYTES) + ext);
    end
  endfunction

  // Bus decode; the answer comes one cycle after the request appears.
  assign access   = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr_ev    = access && wb_we_i && wb_sel_i[0];
  assign mem_widx = 6'(wb_adr_i[7:2]);
  assign mem_hit  = (wb_adr_i[11:8] == DDB_OFF_DATA[11:8]) &&
                    (mem_widx < 6'(DDB_DATA_BYTES));

  always_ff @(posedge ref_clk) begin
    if (wr_ev && mem_hit) begin
      data_mem[mem_widx] <= wb_dat_i[7:0];
    end
  end

  assign mem_ridx = st.idx - 6'(DDB_HDR_BYTES);
  assign mem_byte = (mem_ridx < 6'(DDB_DATA_BYTES)) ? data_mem[mem_ridx]
                                                    : 8'h00;

  // Byte selected by the current position in the block.
  always_comb begin
    logic [7:0] slot0;
    logic [7:0] pm;
    slot0    = 8'h00;
    pm       = 8'h00;
    cur_byte = 8'h00;
    case (st.idx)
      6'h00: cur_byte = {DDB_BLOCK_ID, st.s_len};
      6'h01: cur_byte = st.s_head;
      6'h02: cur_byte = st.s_slot;
      6'h03: begin
        if (st.s_head[DDB_HEAD_VAR] == DDB_VAR_ALARM) begin
          cur_byte = {st.s_seq, st.s_spec};
        end else begin
          cur_byte = {6'h00, st.s_spec[1:0]};
        end
      end
      default: begin
        if (st.s_head == {DDB_VAR_STATUS, DDB_ST_MODULE}) begin
          // Slot numbers of the four pairs start at 4*k+1.
          slot0 = 8'({mem_ridx, 2'b00});
          for (int p = 0; p < 4; p++) begin
            if (slot0 + 8'(p) < st.s_nslot) begin
              pm[2*p +: 2] = mem_byte[2*p +: 2];
            end else begin
              pm[2*p +: 2] = 2'b00;
            end
          end
          cur_byte = pm;
        end else begin
          cur_byte = mem_byte;
        end
      end
    endcase
  end

  assign f_in_valid  = st.fsm == DDB_EMIT;
  assign f_in_data   = {st.idx == st.s_len - 6'h01, cur_byte};
  assign f_out_ready = !st.o_valid || diag_ready;
  assign start_req   = wr_ev && (wb_adr_i == DDB_OFF_CTRL) &&
                       wb_dat_i[DDB_CTRL_START];

  always_comb begin
    logic launch;
    logic from_pend;
    logic [4:0] sts;
    launch    = 1'b0;
    from_pend = 1'b0;
    sts       = 5'h00;
    next_st   = st;

    // Wishbone answer: ack drops in the cycle after it was given.
    next_st.ack = access;
    if (access && !wb_we_i) begin
      sts = {st.ackw, st.repl, st.err, st.pend, st.fsm == DDB_EMIT};
      case (wb_adr_i)
        DDB_OFF_CTRL:   next_st.rdata = {31'h0, st.fsm == DDB_EMIT};
        DDB_OFF_HEAD:   next_st.rdata = {24'h0, st.head};
        DDB_OFF_SLOT:   next_st.rdata = {24'h0, st.slot};
        DDB_OFF_SPEC:   next_st.rdata = {29'h0, st.spec};
        DDB_OFF_NSLOT:  next_st.rdata = {24'h0, st.nslot};
        DDB_OFF_EXTLEN: next_st.rdata = {26'h0, st.extlen};
        DDB_OFF_STATUS: next_st.rdata = {19'h0, st.seq, 3'h0, sts};
        default: begin
          next_st.rdata = mem_hit ? {24'h0, data_mem[mem_widx]} : 32'h0;
        end
      endcase
    end

    if (wr_ev) begin
      case (wb_adr_i)
        DDB_OFF_HEAD:   next_st.head   = wb_dat_i[7:0];
        DDB_OFF_SLOT:   next_st.slot   = wb_dat_i[7:0];
        DDB_OFF_SPEC:   next_st.spec   = wb_dat_i[2:0];
        DDB_OFF_NSLOT:  next_st.nslot  = wb_dat_i[7:0];
        DDB_OFF_EXTLEN: next_st.extlen = wb_dat_i[5:0];
        DDB_OFF_STATUS: begin
          if (wb_dat_i[DDB_ST_ERR]) begin
            next_st.err = 1'b0;
          end
          if (wb_dat_i[DDB_ST_REPL]) begin
            next_st.repl = 1'b0;
          end
        end
        DDB_OFF_ACK: begin
          if (wb_dat_i[DDB_ACK_CLR]) begin
            next_st.ackw = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // A request during a build waits; a second one overwrites the first.
    if (start_req) begin
      if (st.fsm == DDB_EMIT || st.pend) begin
        next_st.pend = 1'b1;
        if (st.pend) begin
          next_st.repl = 1'b1;
        end
      end else begin
        launch = 1'b1;
      end
    end

    case (st.fsm)
      DDB_IDLE: begin
        if (st.pend) begin
          launch    = 1'b1;
          from_pend = 1'b1;
        end
      end
      DDB_EMIT: begin
        if (f_in_ready) begin
          if (st.idx == st.s_len - 6'h01) begin
            next_st.fsm = DDB_IDLE;
          end else begin
            next_st.idx = st.idx + 6'h01;
          end
        end
      end
      default: next_st.fsm = DDB_IDLE;
    endcase

    if (launch) begin
      if (from_pend && !start_req) begin
        next_st.pend = 1'b0;
      end
      if (code_ok(st.head, st.spec)) begin
        next_st.fsm     = DDB_EMIT;
        next_st.idx     = 6'h00;
        next_st.s_head  = st.head;
        next_st.s_slot  = st.slot;
        next_st.s_spec  = st.spec;
        next_st.s_seq   = st.seq;
        next_st.s_nslot = (st.nslot > DDB_MAX_SLOTS) ? DDB_MAX_SLOTS
                                                     : st.nslot;
        next_st.s_len   = block_len(st.head, st.nslot, st.extlen);
        if (st.head[DDB_HEAD_VAR] == DDB_VAR_ALARM) begin
          next_st.seq = st.seq + 5'h01;
          if (st.spec[DDB_SPEC_ADDACK]) begin
            // Setting wins over a clear in the same cycle.
            next_st.ackw = 1'b1;
          end
        end else begin
          next_st.s_spec[DDB_SPEC_ADDACK] = 1'b0;
        end
      end else begin
        next_st.err = 1'b1;
      end
    end

    // Output register in front of the stream port.
    if (f_out_ready) begin
      next_st.o_valid = f_out_valid;
      next_st.o_data  = f_out_data[7:0];
      next_st.o_last  = f_out_data[8];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st        <= '0;
      st.fsm    <= DDB_IDLE;
      st.head   <= DDB_RST_HEAD;
      st.slot   <= DDB_RST_SLOT;
      st.nslot  <= DDB_RST_NSLOT;
      st.extlen <= DDB_RST_EXTLEN;
      st.seq    <= DDB_RST_SEQ;
    end else begin
      st <= next_st;
    end
  end

  ddb_fifo #(
    .W     (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  assign wb_ack_o   = st.ack;
  assign wb_dat_o   = st.rdata;
  assign diag_valid = st.o_valid;
  assign diag_data  = st.o_data;
  assign diag_last  = st.o_last;
  assign diag_busy  = st.fsm == DDB_EMIT;
  assign ack_wait   = st.ackw;
endmodule
`default_nettype wire

// [logic/ddb_pkg.sv]
// Shared constants for the diagnostic block builder.
// Assumes a 32-bit classic Wishbone register bus and an 8-bit byte stream.
`default_nettype none
package ddb_pkg;

  // Register byte offsets.
  localparam logic [11:0] DDB_OFF_CTRL   = 12'h000;
  localparam logic [11:0] DDB_OFF_HEAD   = 12'h004;
  localparam logic [11:0] DDB_OFF_SLOT   = 12'h008;
  localparam logic [11:0] DDB_OFF_SPEC   = 12'h00c;
  localparam logic [11:0] DDB_OFF_NSLOT  = 12'h010;
  localparam logic [11:0] DDB_OFF_EXTLEN = 12'h014;
  localparam logic [11:0] DDB_OFF_STATUS = 12'h018;
  localparam logic [11:0] DDB_OFF_ACK    = 12'h01c;
  localparam logic [11:0] DDB_OFF_DATA   = 12'h100;

  // Field positions.
  localparam int DDB_CTRL_START  = 0;
  localparam int DDB_HEAD_VAR    = 7;
  localparam int DDB_SPEC_ADDACK = 2;
  localparam int DDB_ST_BUSY     = 0;
  localparam int DDB_ST_PEND     = 1;
  localparam int DDB_ST_ERR      = 2;
  localparam int DDB_ST_REPL     = 3;
  localparam int DDB_ST_ACKW     = 4;
  localparam int DDB_ST_SEQ      = 8;
  localparam int DDB_ACK_CLR     = 0;

  // Block geometry.
  localparam int          DDB_HDR_BYTES  = 4;
  localparam int          DDB_DATA_BYTES = 59;
  localparam logic [7:0]  DDB_MAX_SLOTS  = 8'hec;
  localparam logic [1:0]  DDB_BLOCK_ID   = 2'h0;

  // Variant bit and type codes.
  localparam logic        DDB_VAR_ALARM  = 1'b0;
  localparam logic        DDB_VAR_STATUS = 1'b1;
  localparam logic [6:0]  DDB_AT_FIRST   = 7'h01;
  localparam logic [6:0]  DDB_AT_LAST    = 7'h06;
  localparam logic [6:0]  DDB_AT_STATUS  = 7'h05;
  localparam logic [6:0]  DDB_ST_MSG     = 7'h01;
  localparam logic [6:0]  DDB_ST_MODULE  = 7'h02;
  localparam logic [6:0]  DDB_VEND_FIRST = 7'h20;
  localparam logic [6:0]  DDB_VEND_LAST  = 7'h7e;
  localparam logic [1:0]  DDB_SSPEC_RSVD = 2'h3;

  // Reset values.
  localparam logic [7:0]  DDB_RST_HEAD   = 8'h01;
  localparam logic [7:0]  DDB_RST_SLOT   = 8'h00;
  localparam logic [7:0]  DDB_RST_NSLOT  = 8'h00;
  localparam logic [5:0]  DDB_RST_EXTLEN = 6'h00;
  localparam logic [4:0]  DDB_RST_SEQ    = 5'h00;

  // Bus answer: one wait state from request to acknowledge.
  localparam int          DDB_WB_LATENCY = 1;

endpackage
`default_nettype wire

// [logic/ddb_fifo.sv]
// Synchronous FIFO with valid/ready handshakes on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none
module ddb_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // Filling side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } ddb_fifo_s;

  ddb_fifo_s        st;
  ddb_fifo_s        next_st;
  logic [W-1:0]     mem [DEPTH];
  logic             full;
  logic             empty;

  assign full      = (st.wr_ptr[AW] != st.rd_ptr[AW]) &&
                     (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]);
  assign empty     = st.wr_ptr == st.rd_ptr;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[st.rd_ptr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (in_valid && !full) begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (in_valid && !full) begin
      mem[st.wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// [dv/ddb_checker.sv]
// Port assertions for the diagnostic block builder.
// Assumes it is bound to each ddb_builder instance.
`timescale 1ns/1ps
`default_nettype none
module ddb_checker (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        nrst,
  // Wishbone slave.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Byte stream and status.
  input wire logic        diag_valid,
  input wire logic [7:0]  diag_data,
  input wire logic        diag_last,
  input wire logic        diag_ready,
  input wire logic        diag_busy,
  input wire logic        ack_wait
);
  import ddb_pkg::*;
  // Position in the current block as the far side counts it.
  logic       first_q;
  logic       var_q;
  logic [5:0] idx_q;
  logic [5:0] len_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      first_q <= 1'b1;
      var_q   <= 1'b0;
      idx_q   <= 6'h00;
      len_q   <= 6'h00;
    end else if (diag_valid && diag_ready) begin
      first_q <= diag_last;
      idx_q   <= diag_last ? 6'h00 : idx_q + 6'h01;
      if (first_q) len_q <= diag_data[5:0];
      if (idx_q == 6'h01) var_q <= diag_data[7];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence last_take;
    diag_valid && diag_ready && diag_last && !first_q;
  endsequence
  bus_answer_a: assert property (bus_req |=> wb_ack_o)
    else $error("bus answer missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  stream_hold_a: assert property (diag_valid && !diag_ready |=> diag_valid
    && $stable(diag_data) && $stable(diag_last)) else $error("byte dropped");
  header_tag_a: assert property (
    diag_valid && first_q |-> diag_data[7:6] == DDB_BLOCK_ID)
    else $error("header top bits set");
  block_len_a: assert property (
    last_take |-> idx_q + 6'h01 == len_q) else $error("length mismatch");
  type_code_a: assert property (diag_valid && idx_q == 6'h01 |->
    diag_data[6:0] inside {[7'h20:7'h7e]} || (diag_data[7] ?
    diag_data[6:0] inside {[1:2]} : diag_data[6:0] inside {[1:6]}))
    else $error("reserved type sent");
  status_spec_a: assert property (diag_valid && idx_q == 6'h03 && var_q
    |-> diag_data[7:2] == 6'h00 && diag_data[1:0] != DDB_SSPEC_RSVD)
    else $error("bad status specifier");
  add_ack_a: assert property (diag_valid && idx_q == 6'h03 && !var_q
    && diag_data[2] |-> ack_wait) else $error("ack wait not raised");
  block_bound_a: assert property (
    diag_valid && !first_q |-> idx_q < len_q) else $error("byte past end");
endmodule
bind ddb_builder ddb_checker u_chk (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .diag_valid, .diag_data, .diag_last, .diag_ready, .diag_busy, .ack_wait);
`default_nettype wire

// [dv/ddb_sink.sv]
// Far-side byte sink standing in for the master reading diagnostics.
// Assumes one clock; stall_mode 0 takes all, 1 one byte in four, 2 none.
`timescale 1ns/1ps
`default_nettype none
module ddb_sink (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Diagnostic byte stream.
  input  wire logic       diag_valid,
  input  wire logic [7:0] diag_data,
  input  wire logic       diag_last,
  output logic            diag_ready,
  // Pace set by the bench.
  input  wire logic [1:0] stall_mode
);
  logic [7:0] rx [256];
  int         n;
  int         blk;
  logic [1:0] pace;
  // Bytes form one flat record; the bench splits blocks by count.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      n          <= 0;
      blk        <= 0;
      pace       <= 2'h0;
      diag_ready <= 1'b0;
    end else begin
      pace       <= pace + 2'h1;
      diag_ready <= stall_mode == 2'h0 || (stall_mode == 2'h1 && pace == 2'h0);
      if (diag_valid && diag_ready) begin
        rx[n] <= diag_data;
        n     <= n + 1;
        if (diag_last) blk <= blk + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/ddb_builder_bench.sv]
// Self-checking bench for the diagnostic block builder.
// Assumes ddb_sink records the stream; clock 125 MHz.
`timescale 1ns/1ps
`default_nettype none
module ddb_builder_bench;
  import ddb_pkg::*;
  localparam logic [55:0] rsvd = 56'h00071f7f83ff81;
  logic        ref_clk;
  logic        nrst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        diag_valid;
  logic [7:0]  diag_data;
  logic        diag_last;
  logic        diag_ready;
  logic        diag_busy;
  logic        ack_wait;
  logic [1:0]  stall_mode;
  logic [7:0]  eb [64];
  logic [31:0] q;
  int          num_errors;
  int          samples_checked;
  int          i;
  int          n0;
  int          b0;

  ddb_builder #(.FIFO_DEPTH(8)) u_dut (.ref_clk, .nrst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .diag_valid, .diag_data, .diag_last, .diag_ready,
    .diag_busy, .ack_wait);
  ddb_sink u_sink (.ref_clk, .nrst, .diag_valid, .diag_data, .diag_last,
    .diag_ready, .stall_mode);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wb(input logic [11:0] a, input logic w,
                    input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    if (k >= 50) begin
      num_errors++;
      results();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(a, 1'b1, d, 4'hf);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, e);
    wb(a, 1'b0, 32'h0, 4'hf);
    check("register", q & m, e);
  endtask

  task automatic wait_blk(input int n);
    int k;
    k = 0;
    while (u_sink.blk != n && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 2000) begin
      num_errors++;
      results();
    end
  endtask

  // Starts one build and compares the whole block seen by the sink.
  task automatic go(input int n);
    int b;
    b = u_sink.n;
    eb[0] = 8'(n);
    wr(DDB_OFF_CTRL, 32'h1);
    wait_blk(u_sink.blk + 1);
    check("length", 32'(u_sink.n - b), 32'(n));
    for (int j = 0; j < n; j++) check("byte", u_sink.rx[b + j], eb[j]);
  endtask

  initial begin
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    stall_mode = 2'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    for (i = 0; i < 7; i++) rdc(12'(4 * i), '1, i == 1 ? 32'h1 : 32'h0);
    rdc(12'h040, '1, 32'h0);
    $display("reset test done");
    wr(DDB_OFF_EXTLEN, 32'h2);
    wr(DDB_OFF_DATA, 32'h5a);
    wr(DDB_OFF_DATA + 12'h4, 32'ha5);
    rdc(DDB_OFF_DATA + 12'h4, 32'hff, 32'ha5);
    wr(DDB_OFF_SLOT, 32'h3);
    eb[2] = 8'h03;
    eb[4] = 8'h5a;
    eb[5] = 8'ha5;
    for (i = 0; i < 8; i++) begin
      eb[1] = i < 6 ? 8'(i + 1) : (i == 6 ? 8'h20 : 8'h7e);
      eb[3] = {i[4:0], 1'b0, i[1:0]};
      wr(DDB_OFF_HEAD, {24'h0, eb[1]});
      wr(DDB_OFF_SPEC, {30'h0, i[1:0]});
      go(6);
    end
    wr(DDB_OFF_SPEC, 32'h5);
    eb[3] = 8'h45;
    go(6);
    check("ack_wait", ack_wait, 1'b1);
    rdc(DDB_OFF_STATUS, 32'h1f10, 32'h0910);
    wr(DDB_OFF_ACK, 32'h1);
    check("ack_wait", ack_wait, 1'b0);
    $display("alarm test done");
    wr(DDB_OFF_SLOT, 32'h0);
    wr(DDB_OFF_EXTLEN, 32'h0);
    eb[2] = 8'h00;
    for (i = 1; i < 3; i++) begin
      eb[1] = i == 1 ? 8'h81 : 8'hb0;
      eb[3] = 8'(i);
      wr(DDB_OFF_HEAD, {24'h0, eb[1]});
      wr(DDB_OFF_SPEC, 32'(4 + i));
      go(4);
    end
    wr(DDB_OFF_NSLOT, 32'h5);
    wr(DDB_OFF_DATA, 32'he4);
    wr(DDB_OFF_DATA + 12'h4, 32'hff);
    wr(DDB_OFF_HEAD, 32'h82);
    wr(DDB_OFF_SPEC, 32'h0);
    eb[1] = 8'h82;
    eb[3] = 8'h00;
    eb[4] = 8'he4;
    eb[5] = 8'h03;
    go(6);
    for (i = 0; i < 59; i++) begin
      eb[4 + i] = 8'(i * 7 + 1);
      wr(DDB_OFF_DATA + 12'(4 * i), {24'h0, eb[4 + i]});
    end
    wr(DDB_OFF_NSLOT, 32'hec);
    stall_mode <= 2'h1;
    go(63);
    stall_mode <= 2'h0;
    $display("status test done");
    for (i = 0; i < 7; i++) begin
      wr(DDB_OFF_HEAD, {24'h0, rsvd[8 * i +: 8]});
      wr(DDB_OFF_SPEC, i == 0 ? 32'h3 : 32'h1);
      wr(DDB_OFF_CTRL, 32'h1);
      rdc(DDB_OFF_STATUS, 32'h7, 32'h4);
      wr(DDB_OFF_STATUS, 32'h4);
    end
    rdc(DDB_OFF_STATUS, 32'h7, 32'h0);
    wb(DDB_OFF_SLOT, 1'b1, 32'h9, 4'h0);
    rdc(DDB_OFF_SLOT, 32'hff, 32'h0);
    $display("reserved test done");
    stall_mode <= 2'h2;
    wr(DDB_OFF_EXTLEN, 32'h14);
    wr(DDB_OFF_HEAD, 32'h05);
    wr(DDB_OFF_SLOT, 32'h1);
    n0 = u_sink.n;
    b0 = u_sink.blk;
    wr(DDB_OFF_CTRL, 32'h1);
    wr(DDB_OFF_SLOT, 32'h2);
    wr(DDB_OFF_CTRL, 32'h1);
    wr(DDB_OFF_SLOT, 32'h7);
    wr(DDB_OFF_CTRL, 32'h1);
    rdc(DDB_OFF_STATUS, 32'hb, 32'hb);
    check("diag_busy", diag_busy, 1'b1);
    stall_mode <= 2'h0;
    wait_blk(b0 + 2);
    check("slot", u_sink.rx[n0 + 26], 8'h07);
    check("bytes", 32'(u_sink.n - n0), 32'd48);
    check("diag_busy", diag_busy, 1'b0);
    wr(DDB_OFF_STATUS, 32'h8);
    rdc(DDB_OFF_STATUS, 32'h8, 32'h0);
    $display("replace test done");
    results();
  end
endmodule
`default_nettype wire
